// *** ulc_pkg.sv ***
package ulc_pkg;
   // Master clock and serial timing
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned MASTER_OSC_HZ = 16_000_000;
   localparam int unsigned BAUD_RATE = 115_200;
   localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_RATE;
   localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
   localparam int unsigned DATA_BITS = 8;
   localparam int unsigned FIFO_DEPTH = 8;
   // Reset pin hold time
   localparam int unsigned RESET_HOLD_MS = 100;
   localparam int unsigned RESET_HOLD_CYCLES = RESET_HOLD_MS * (CLK_HZ / 1000);
   // Command text characters and dimming reset value
   localparam logic [7:0] CHR_A = 8'h41;
   localparam logic [7:0] CHR_T = 8'h54;
   localparam logic [7:0] CHR_O = 8'h4F;
   localparam logic [7:0] CHR_K = 8'h4B;
   localparam logic [7:0] CHR_CR = 8'h0D;
   localparam logic [7:0] CHR_LF = 8'h0A;
   localparam logic [7:0] CHR_EQ = 8'h3D;
   localparam logic [7:0] CHR_0 = 8'h30;
   localparam logic [7:0] CHR_9 = 8'h39;
   localparam logic [15:0] DIM_RESET = 16'h0000;
endpackage

// *** ulc_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface ulc_link_if;
   logic dev_to_host; // Device transmit line
   logic host_to_dev; // Device receive line
   modport dev (output dev_to_host, input host_to_dev);
   modport host (input dev_to_host, output host_to_dev);
endinterface
`default_nettype wire

// *** ulc_host_end.sv ***
`timescale 1ns/1ps
`default_nettype none
// Host end: sends and receives 8N1 characters at 115.2 kbaud
module ulc_host_end
   import ulc_pkg::*;
#(
   parameter int unsigned BIT_CYC = BIT_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   ulc_link_if.host link,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic rx_frame_err
);
   logic [15:0] tx_cnt_r;
   logic [3:0] tx_bit_r;
   logic [9:0] tx_sh_r;
   logic tx_busy_r;
   logic txd_r;
   logic rxd_s_r;
   logic rx_busy_r;
   logic [15:0] rx_cnt_r;
   logic [3:0] rx_bit_r;
   logic [7:0] rx_sh_r;

   assign link.host_to_dev = txd_r;

   // Transmitter: start low, 8 data lsb first, one stop high
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_busy_r <= 1'b0;
         tx_ready <= 1'b1;
         txd_r <= 1'b1;
         tx_cnt_r <= 16'h0000;
         tx_bit_r <= 4'h0;
         tx_sh_r <= 10'h3FF;
      end else if (!tx_busy_r) begin
         txd_r <= 1'b1;
         if (tx_valid) begin
            tx_sh_r <= {1'b1, tx_data, 1'b0};
            tx_busy_r <= 1'b1;
            tx_ready <= 1'b0; // Busy for the whole frame
            tx_cnt_r <= 16'h0000;
            tx_bit_r <= 4'h0;
         end
      end else begin
         txd_r <= tx_sh_r[0];
         if (tx_cnt_r == 16'(BIT_CYC - 1)) begin
            tx_cnt_r <= 16'h0000;
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            if (tx_bit_r == 4'd9) begin
               tx_busy_r <= 1'b0;
               tx_ready <= 1'b1;
            end else begin
               tx_bit_r <= tx_bit_r + 4'h1;
            end
         end else begin
            tx_cnt_r <= tx_cnt_r + 16'h0001;
         end
      end
   end

   // Receiver: centre sampling, stop checked
   always_ff @(posedge clk) begin
      if (rst) begin
         rxd_s_r <= 1'b1;
         rx_busy_r <= 1'b0;
         rx_cnt_r <= 16'h0000;
         rx_bit_r <= 4'h0;
         rx_sh_r <= 8'h00;
         rx_data <= 8'h00;
         rx_valid <= 1'b0;
         rx_frame_err <= 1'b0;
      end else begin
         rxd_s_r <= link.dev_to_host;
         rx_valid <= 1'b0;
         rx_frame_err <= 1'b0;
         if (!rx_busy_r) begin
            if (rxd_s_r && !link.dev_to_host) begin
               rx_busy_r <= 1'b1;
               rx_cnt_r <= 16'(BIT_CYC / 2);
               rx_bit_r <= 4'h0;
            end
         end else if (rx_cnt_r == 16'(BIT_CYC - 1)) begin
            rx_cnt_r <= 16'h0000;
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == 4'd0 && link.dev_to_host) begin
               rx_busy_r <= 1'b0;
            end else if (rx_bit_r >= 4'd1 && rx_bit_r <= 4'd8) begin
               rx_sh_r <= {link.dev_to_host, rx_sh_r[7:1]};
            end else if (rx_bit_r == 4'd9) begin
               rx_busy_r <= 1'b0;
               rx_data <= rx_sh_r;
               rx_valid <= link.dev_to_host;
               rx_frame_err <= !link.dev_to_host;
            end
         end else begin
            rx_cnt_r <= rx_cnt_r + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

// *** ulc_dev_end.sv ***
`timescale 1ns/1ps
`default_nettype none
// How it works
// - All timing from the master clock
// - Full duplex, eight-byte queue each way
// - Both ends run 115.2 kbaud
// - Eight data bits, no parity, one stop
// - Queued byte loads shifter and transmits
// - Start low, stop high, idle high
// - Falling edge when idle starts reception
// - Stop bit sampled and checked high
// - Text attention commands answered with OK
// - Dimming from analog input or commands
// - Interpreter sits between port and core
// - Reset pin low over 100 ms resets
module ulc_dev_end
   import ulc_pkg::*;
#(
   parameter int unsigned BIT_CYC = BIT_CYCLES,
   parameter int unsigned DEPTH = FIFO_DEPTH,
   parameter int unsigned RST_HOLD = RESET_HOLD_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   ulc_link_if.dev link,
   input wire logic sync_reset_pin_n,
   input wire logic [9:0] analog_dimming_input,
   output logic [15:0] dim_level,
   output logic dim_from_cmd,
   output logic [15:0] lux_target_command,
   output logic lux_target_valid,
   output logic frame_err,
   output logic overrun,
   output logic core_reset
);
   typedef enum logic [1:0] {
      PS_IDLE = 2'b00, PS_A = 2'b01, PS_CMD = 2'b10
   } ulc_parse_e;

   logic [31:0] hold_cnt_r;
   logic srst;
   logic [7:0] rxq [DEPTH];
   logic [7:0] txq [DEPTH];
   logic [3:0] rxq_wr_r, rxq_rd_r, txq_wr_r, txq_rd_r;
   logic rxq_full, rxq_empty, txq_full, txq_empty;
   logic txd_r, tx_busy_r;
   logic [15:0] tx_cnt_r;
   logic [3:0] tx_bit_r;
   logic [9:0] tx_sh_r;
   logic rxd_s_r, rx_busy_r;
   logic [15:0] rx_cnt_r;
   logic [3:0] rx_bit_r;
   logic [7:0] rx_sh_r;
   logic rx_push;
   logic [7:0] rx_byte;
   ulc_parse_e ps_r;
   logic [15:0] num_r;
   logic [1:0] ack_r;
   logic [7:0] cmd_byte;
   logic tx_push;
   logic [7:0] tx_byte;

   assign rxq_empty = rxq_wr_r == rxq_rd_r;
   assign rxq_full = (rxq_wr_r[2:0] == rxq_rd_r[2:0]) && (rxq_wr_r[3] != rxq_rd_r[3]);
   assign txq_empty = txq_wr_r == txq_rd_r;
   assign txq_full = (txq_wr_r[2:0] == txq_rd_r[2:0]) && (txq_wr_r[3] != txq_rd_r[3]);
   assign srst = rst || core_reset;
   assign link.dev_to_host = txd_r;
   assign cmd_byte = rxq[rxq_rd_r[2:0]];

   // Reset pin held low long enough resets the port and interpreter
   always_ff @(posedge clk) begin
      if (rst) begin
         hold_cnt_r <= 32'h00000000;
         core_reset <= 1'b0;
      end else if (sync_reset_pin_n) begin
         hold_cnt_r <= 32'h00000000;
         core_reset <= 1'b0;
      end else if (hold_cnt_r >= 32'(RST_HOLD)) begin
         core_reset <= 1'b1;
      end else begin
         hold_cnt_r <= hold_cnt_r + 32'h00000001;
      end
   end

   // Transmitter fed by the transmit queue, clock-derived bit timing
   always_ff @(posedge clk) begin
      if (srst) begin
         tx_busy_r <= 1'b0;
         txd_r <= 1'b1;
         tx_cnt_r <= 16'h0000;
         tx_bit_r <= 4'h0;
         tx_sh_r <= 10'h3FF;
         txq_rd_r <= 4'h0;
      end else if (!tx_busy_r) begin
         txd_r <= 1'b1;
         if (!txq_empty) begin
            tx_sh_r <= {1'b1, txq[txq_rd_r[2:0]], 1'b0};
            txq_rd_r <= txq_rd_r + 4'h1;
            tx_busy_r <= 1'b1;
            tx_cnt_r <= 16'h0000;
            tx_bit_r <= 4'h0;
         end
      end else begin
         txd_r <= tx_sh_r[0];
         if (tx_cnt_r == 16'(BIT_CYC - 1)) begin
            tx_cnt_r <= 16'h0000;
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            if (tx_bit_r == 4'd9) begin
               tx_busy_r <= 1'b0;
            end else begin
               tx_bit_r <= tx_bit_r + 4'h1;
            end
         end else begin
            tx_cnt_r <= tx_cnt_r + 16'h0001;
         end
      end
   end

   // Transmit queue write side
   always_ff @(posedge clk) begin
      if (srst) begin
         txq_wr_r <= 4'h0;
      end else if (tx_push && !txq_full) begin
         txq[txq_wr_r[2:0]] <= tx_byte;
         txq_wr_r <= txq_wr_r + 4'h1;
      end
   end

   // Receiver: falling edge start, centre sampling, stop check
   always_ff @(posedge clk) begin
      if (srst) begin
         rxd_s_r <= 1'b1;
         rx_busy_r <= 1'b0;
         rx_cnt_r <= 16'h0000;
         rx_bit_r <= 4'h0;
         rx_sh_r <= 8'h00;
         rx_push <= 1'b0;
         rx_byte <= 8'h00;
         frame_err <= 1'b0;
      end else begin
         rxd_s_r <= link.host_to_dev;
         rx_push <= 1'b0;
         frame_err <= 1'b0;
         if (!rx_busy_r) begin
            if (rxd_s_r && !link.host_to_dev) begin
               rx_busy_r <= 1'b1;
               rx_cnt_r <= 16'(BIT_CYC / 2);
               rx_bit_r <= 4'h0;
            end
         end else if (rx_cnt_r == 16'(BIT_CYC - 1)) begin
            rx_cnt_r <= 16'h0000;
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == 4'd0 && link.host_to_dev) begin
               rx_busy_r <= 1'b0; // False start
            end else if (rx_bit_r >= 4'd1 && rx_bit_r <= 4'd8) begin
               rx_sh_r <= {link.host_to_dev, rx_sh_r[7:1]};
            end else if (rx_bit_r == 4'd9) begin
               rx_busy_r <= 1'b0;
               rx_byte <= rx_sh_r;
               rx_push <= link.host_to_dev;
               frame_err <= !link.host_to_dev;
            end
         end else begin
            rx_cnt_r <= rx_cnt_r + 16'h0001;
         end
      end
   end

   // Receive queue write side, drop on full
   always_ff @(posedge clk) begin
      if (srst) begin
         rxq_wr_r <= 4'h0;
         overrun <= 1'b0;
      end else begin
         overrun <= rx_push && rxq_full;
         if (rx_push && !rxq_full) begin
            rxq[rxq_wr_r[2:0]] <= rx_byte;
            rxq_wr_r <= rxq_wr_r + 4'h1;
         end
      end
   end

   // Interpreter: AT<cmd>[=num]<CR or LF> sets target, replies OK CR
   always_ff @(posedge clk) begin
      if (srst) begin
         rxq_rd_r <= 4'h0;
         ps_r <= PS_IDLE;
         num_r <= 16'h0000;
         ack_r <= 2'b00;
         tx_push <= 1'b0;
         tx_byte <= 8'h00;
         lux_target_command <= DIM_RESET;
         lux_target_valid <= 1'b0;
      end else begin
         tx_push <= 1'b0;
         lux_target_valid <= 1'b0;
         if (ack_r != 2'b00 || tx_push) begin
            if (!tx_push && !txq_full) begin
               tx_push <= 1'b1;
               case (ack_r)
                  2'b11: tx_byte <= CHR_O;
                  2'b10: tx_byte <= CHR_K;
                  default: tx_byte <= CHR_CR;
               endcase
               ack_r <= ack_r - 2'b01;
            end
         end else if (!rxq_empty) begin
            rxq_rd_r <= rxq_rd_r + 4'h1;
            case (ps_r)
               PS_IDLE: ps_r <= (cmd_byte == CHR_A) ? PS_A : PS_IDLE;
               PS_A: begin
                  ps_r <= (cmd_byte == CHR_T) ? PS_CMD : PS_IDLE;
                  num_r <= 16'h0000;
               end
               PS_CMD: begin
                  if (cmd_byte == CHR_CR || cmd_byte == CHR_LF) begin
                     lux_target_command <= num_r;
                     lux_target_valid <= 1'b1;
                     ack_r <= 2'b11;
                     ps_r <= PS_IDLE;
                  end else if (cmd_byte >= CHR_0 && cmd_byte <= CHR_9) begin
                     num_r <= 16'(num_r * 16'd10 + 16'(cmd_byte - CHR_0));
                  end
               end
               default: ps_r <= PS_IDLE;
            endcase
         end
      end
   end

   // Dimming source: analog input until a command arrives
   always_ff @(posedge clk) begin
      if (srst) begin
         dim_from_cmd <= 1'b0;
         dim_level <= DIM_RESET;
      end else if (lux_target_valid) begin
         dim_from_cmd <= 1'b1;
         dim_level <= lux_target_command;
      end else if (!dim_from_cmd) begin
         dim_level <= {6'h00, analog_dimming_input};
      end
   end
endmodule
`default_nettype wire

// *** ulc_link_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module ulc_link_chk #(
   parameter int BC = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic dev_to_host,
   input wire logic host_to_dev
);
   int dlo, dhi, hlo, hhi;
   // Run lengths of the device line levels
   always_ff @(posedge clk) begin
      dlo <= (rst || dev_to_host) ? 0 : dlo + 1;
      dhi <= rst ? BC : (dev_to_host ? dhi + 1 : 0);
   end
   // Run lengths of the host line levels
   always_ff @(posedge clk) begin
      hlo <= (rst || host_to_dev) ? 0 : hlo + 1;
      hhi <= rst ? BC : (host_to_dev ? hhi + 1 : 0);
   end
   a_dev_idle_high: assert property (@(posedge clk) disable iff (rst) $fell(rst) |-> dev_to_host)
      else $error("device line not idle after reset");
   a_dev_bit_time: assert property (@(posedge clk) disable iff (rst)
      $rose(dev_to_host) |-> dlo != 0 && dlo % BC == 0)
      else $error("device low run not whole bits");
   a_dev_low_max: assert property (@(posedge clk) disable iff (rst) $rose(dev_to_host) |-> dlo <= 9 * BC)
      else $error("device low run too long");
   a_dev_stop_min: assert property (@(posedge clk) disable iff (rst) $fell(dev_to_host) |-> dhi >= BC)
      else $error("device stop bit too short");
   a_host_idle_high: assert property (@(posedge clk) disable iff (rst) $fell(rst) |-> host_to_dev)
      else $error("host line not idle after reset");
   a_host_bit_time: assert property (@(posedge clk) disable iff (rst)
      $rose(host_to_dev) |-> hlo != 0 && hlo % BC == 0)
      else $error("host low run not whole bits");
   a_host_low_max: assert property (@(posedge clk) disable iff (rst) $rose(host_to_dev) |-> hlo <= 9 * BC)
      else $error("host low run too long");
   a_host_stop_min: assert property (@(posedge clk) disable iff (rst) $fell(host_to_dev) |-> hhi >= BC)
      else $error("host stop bit too short");
endmodule
`default_nettype wire

// *** test_uart_lighting_command_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_uart_lighting_command_port;
   import ulc_pkg::*;
   localparam int BC = 16;
   localparam int RH = 50;
   logic clk = 1'h0, rst = 1'h1, tx_valid = 1'h0, pin_n = 1'h1, bad_line = 1'h1;
   logic [7:0] tx_data = 8'h00;
   logic [9:0] ana = 10'h000;
   logic [7:0] rx_data;
   logic rx_valid, rx_frame_err, tx_ready, fe_b, fe_a, ov_a, ov_b, core_reset, dim_from_cmd, lux_target_valid;
   logic [15:0] dim_level, lux_target_command;
   logic [15:0] lfsr = 16'hA867;
   logic [7:0] rxq[$];
   logic [7:0] ok3 [3] = '{CHR_O, CHR_K, CHR_CR};
   int err_total = 0, samples_checked = 0, cyc = 0, nlux = 0, nfe = 0, nrfe = 0, nfe_a = 0, nov = 0;
   ulc_link_if link();
   ulc_link_if link_b();
   assign link_b.host_to_dev = bad_line;
   // Clock
   always #5 clk = ~clk;
   ulc_host_end #(.BIT_CYC(BC)) ulc_host_end_i (.clk, .rst, .link(link), .tx_data, .tx_valid, .tx_ready,
      .rx_data, .rx_valid, .rx_frame_err);
   ulc_dev_end #(.BIT_CYC(BC), .RST_HOLD(RH)) ulc_dev_end_i (.clk, .rst, .link(link), .sync_reset_pin_n(pin_n),
      .analog_dimming_input(ana), .dim_level, .dim_from_cmd, .lux_target_command, .lux_target_valid,
      .frame_err(fe_a), .overrun(ov_a), .core_reset);
   // Second device end fed a broken frame
   ulc_dev_end #(.BIT_CYC(BC), .RST_HOLD(RH)) ulc_dev_end_i_b (.clk, .rst, .link(link_b),
      .sync_reset_pin_n(1'h1), .analog_dimming_input(10'h000), .dim_level(), .dim_from_cmd(),
      .lux_target_command(), .lux_target_valid(), .frame_err(fe_b), .overrun(ov_b), .core_reset());
   ulc_link_chk #(.BC(BC)) ulc_link_chk_i (.clk, .rst, .dev_to_host(link.dev_to_host),
      .host_to_dev(link.host_to_dev));
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", n, exp, seen);
      end
   endtask
   // Collect replies and pulses, cut a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rx_valid === 1'h1) rxq.push_back(rx_data);
      if (lux_target_valid === 1'h1) nlux <= nlux + 1;
      if (fe_b === 1'h1) nfe <= nfe + 1;
      if (rx_frame_err === 1'h1) nrfe <= nrfe + 1;
      if (fe_a === 1'h1) nfe_a <= nfe_a + 1;
      if (ov_a === 1'h1 || ov_b === 1'h1) nov <= nov + 1;
      if (cyc == 30000) begin
         err_total++;
         give_verdict();
      end
   end
   task automatic send(input logic [7:0] b);
      @(posedge clk);
      tx_data <= b;
      tx_valid <= 1'h1;
      do @(posedge clk); while (tx_ready !== 1'h1);
      tx_valid <= 1'h0;
   endtask
   task automatic cmd(input logic [15:0] v, input logic [7:0] term);
      string s;
      int n;
      s = $sformatf("AT=%0d", v);
      n = nlux;
      rxq.delete();
      for (int i = 0; i < s.len(); i++) send(s[i]);
      send(term);
      for (int i = 0; i < 2000 && rxq.size() < 3; i++) @(posedge clk);
      chk("reply size", 16'(rxq.size()), 16'h0003);
      for (int i = 0; i < 3; i++) chk("reply char", {8'h00, rxq[i]}, {8'h00, ok3[i]});
      chk("lux target", lux_target_command, v);
      chk("dim level", dim_level, v);
      chk("dim source", 16'(dim_from_cmd), 16'h0001);
      chk("target pulses", 16'(nlux - n), 16'h0001);
   endtask
   // Main sequence
   initial begin
      logic [9:0] fr;
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      lfsr = nxt(lfsr);
      ana <= lfsr[9:0];
      repeat (4) @(posedge clk);
      chk("analog dim", dim_level, {6'h00, ana});
      cmd(16'hFFFF, CHR_CR);
      for (int k = 0; k < 3; k++) begin
         lfsr = nxt(lfsr);
         cmd(lfsr, k[0] ? CHR_LF : CHR_CR);
      end
      cmd(16'h0000, CHR_LF);
      // Frame with a low stop bit on the second end
      lfsr = nxt(lfsr);
      fr = {1'h0, lfsr[7:0], 1'h0};
      for (int i = 0; i < 10; i++) begin
         bad_line <= fr[i];
         repeat (BC) @(posedge clk);
      end
      bad_line <= 1'h1;
      repeat (3 * BC) @(posedge clk);
      chk("frame error pulses", 16'(nfe), 16'h0001);
      chk("host frame errors", 16'(nrfe), 16'h0000);
      chk("device frame errors", 16'(nfe_a), 16'h0000);
      chk("overrun pulses", 16'(nov), 16'h0000);
      // Short hold is ignored, long hold resets
      pin_n <= 1'h0;
      repeat (RH - 20) @(posedge clk);
      chk("short hold", 16'(core_reset), 16'h0000);
      pin_n <= 1'h1;
      @(posedge clk);
      pin_n <= 1'h0;
      repeat (RH + 10) @(posedge clk);
      chk("long hold", 16'(core_reset), 16'h0001);
      pin_n <= 1'h1;
      repeat (5) @(posedge clk);
      chk("dim source reset", 16'(dim_from_cmd), 16'h0000);
      chk("dim after reset", dim_level, {6'h00, ana});
      lfsr = nxt(lfsr);
      cmd(lfsr, CHR_CR);
      give_verdict();
   end
endmodule
`default_nettype wire
